// ---- pkg/ccg_pkg.sv ----
// Constants, types and helpers for the CPU clock generator with clock loss monitor.
package ccg_pkg;
   typedef enum logic [2:0]
   {
      CCG_MUL4 = 3'b111,
      CCG_MUL3 = 3'b110,
      CCG_MUL8 = 3'b101,
      CCG_MUL5 = 3'b100,
      CCG_DIRECT = 3'b011,
      CCG_MUL10 = 3'b010,
      CCG_PRESCALE = 3'b001,
      CCG_MUL16 = 3'b000
   } ccg_mode_t;

   localparam ccg_mode_t CCG_MODE_RESET = CCG_MUL4;
   localparam int CCG_CLK_PERIOD_NS = 40;
   localparam logic [1:0] CCG_CAPTURE_EDGE = 2'h2;
   localparam logic [1:0] CCG_FREE_DIV = 2'h2;
   localparam logic [4:0] CCG_WDT_OVF = 5'h10;
   localparam logic [15:0] CCG_PERIOD_INIT = 16'h0010;
   localparam logic [15:0] CCG_PERIOD_MAX = 16'hFFFF;
   localparam logic [4:0] CCG_WDT_DISABLE_BIT = 5'h04;

   // Multiplication factor of each PLL mode; one for the modes without the PLL.
   function automatic logic [4:0] ccg_factor(input ccg_mode_t m);
      case (m)
         CCG_MUL4: ccg_factor = 5'h04;
         CCG_MUL3: ccg_factor = 5'h03;
         CCG_MUL8: ccg_factor = 5'h08;
         CCG_MUL5: ccg_factor = 5'h05;
         CCG_MUL10: ccg_factor = 5'h0A;
         CCG_MUL16: ccg_factor = 5'h10;
         default: ccg_factor = 5'h01;
      endcase
   endfunction
endpackage

// ---- rtl/ccg_top.sv ----
// CPU clock generator with strap-selected mode and clock loss monitor.
`timescale 1ns/10ps
// Overview of operation
// R01: Mode chosen from three straps at reset.
// R02: Codes select multiply factors 4,3,8,5,10,16.
// R03: Code 001 gives divide-by-two prescaler.
// R04: Prescaler phases each last one input period.
// R05: Code 011 bypasses PLL and oscillator amplifier.
// R06: Direct drive phases follow input duty cycle.
// R07: Non-PLL modes: PLL free-runs unless disabled.
// R08: Monitor enabled after reset; bit disables it.
// R09: Monitor active only in direct or prescaler.
// R10: Counter counts PLL cycles, clears on transition.
// R11: Failure after sixteen PLL cycles without transition.
// R12: Failure switches to PLL, raises request flag.
// R13: Switch-over sticks until next reset.
// R14: Monitor disabled: external clock, PLL off.
// R15: Other codes enable PLL times factor.
// R16: PLL resynchronises gradually every factor transitions.
// R17: Captured mode held until next reset.
module ccg_top
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ext_clock_input_pin,
   input wire logic [2:0] clock_mode_straps,
   input wire logic osc_watchdog_disable,
   output logic cpu_clock_r,
   output logic pll_on_r,
   output logic osc_amp_bypass_r,
   output logic clock_fail_r,
   output logic osc_wdt_irq_r,
   output ccg_pkg::ccg_mode_t mode_r
);
   import ccg_pkg::*;

   logic ext_m_r, ext_s_r, ext_d_r;
   logic [2:0] strap_m_r, strap_s_r;
   logic [1:0] cap_cnt_r;
   logic cap_done_r;
   logic [1:0] free_div_r;
   logic free_tick;
   logic [4:0] wdt_cnt_r;
   logic [15:0] per_cnt_r, period_r, target_r;
   logic [4:0] trans_cnt_r;
   logic [16:0] acc_r, acc_nxt, acc_sub;
   logic [4:0] factor;
   logic ext_edge, ext_rise, non_pll, wdt_active;

   assign ext_edge = ext_s_r ^ ext_d_r;
   assign ext_rise = ext_s_r & ~ext_d_r;
   assign factor = ccg_factor(mode_r);
   assign non_pll = (mode_r == CCG_DIRECT) || (mode_r == CCG_PRESCALE);
   assign wdt_active = cap_done_r && non_pll && !osc_watchdog_disable; // R08 R09
   assign free_tick = (free_div_r == CCG_FREE_DIV - 2'h1);
   assign acc_nxt = acc_r + {11'h000, factor, 1'b0};
   assign acc_sub = acc_nxt - {1'b0, target_r};

   // The clock input pin and the straps are synchronised before any logic looks at them; osc_watchdog_disable is used directly.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ext_m_r <= 1'b0;
         ext_s_r <= 1'b0;
         ext_d_r <= 1'b0;
         strap_m_r <= 3'h7;
         strap_s_r <= 3'h7;
      end
      else
      begin
         ext_m_r <= ext_clock_input_pin;
         ext_s_r <= ext_m_r;
         ext_d_r <= ext_s_r;
         strap_m_r <= clock_mode_straps;
         strap_s_r <= strap_m_r;
      end
   end

   // The straps cannot be read under an asynchronous reset, so they are taken once the
   // synchroniser has filled after release, and never again until the next reset.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cap_cnt_r <= 2'h0;
         cap_done_r <= 1'b0;
         mode_r <= CCG_MODE_RESET;
      end
      else if (!cap_done_r)
      begin
         if (cap_cnt_r == CCG_CAPTURE_EDGE)
         begin
            mode_r <= ccg_mode_t'(strap_s_r); // R01 R02 R03 R05
            cap_done_r <= 1'b1; // R17
         end
         else
         begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
         end
      end
   end

   // Free-running PLL rate, modelled as an enable pulse.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         free_div_r <= 2'h0;
      end
      else if (free_tick)
      begin
         free_div_r <= 2'h0;
      end
      else
      begin
         free_div_r <= free_div_r + 2'h1;
      end
   end

   // PLL power: on in multiply modes, and in the other modes only for the monitor.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pll_on_r <= 1'b0;
         osc_amp_bypass_r <= 1'b0;
      end
      else if (cap_done_r)
      begin
         pll_on_r <= !non_pll || !osc_watchdog_disable; // R07 R14 R15
         osc_amp_bypass_r <= (mode_r == CCG_DIRECT); // R05
      end
   end

   // Clock loss monitor.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wdt_cnt_r <= 5'h00;
         clock_fail_r <= 1'b0;
         osc_wdt_irq_r <= 1'b0;
      end
      else if (!wdt_active || clock_fail_r)
      begin
         wdt_cnt_r <= 5'h00; // R09
      end
      else if (ext_edge)
      begin
         wdt_cnt_r <= 5'h00; // R10
      end
      else if (free_tick)
      begin
         if (wdt_cnt_r == CCG_WDT_OVF - 5'h01)
         begin
            clock_fail_r <= 1'b1; // R11 R13
            osc_wdt_irq_r <= 1'b1; // R12
         end
         else
         begin
            wdt_cnt_r <= wdt_cnt_r + 5'h01; // R10
         end
      end
   end

   // Input period measurement and gradual target update every factor transitions.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         per_cnt_r <= 16'h0000;
         period_r <= CCG_PERIOD_INIT;
         target_r <= CCG_PERIOD_INIT;
         trans_cnt_r <= 5'h00;
      end
      else
      begin
         if (ext_rise)
         begin
            per_cnt_r <= 16'h0000;
            // A stalled input leaves the longest period rather than wrapping to zero.
            period_r <= (per_cnt_r == CCG_PERIOD_MAX) ? CCG_PERIOD_MAX : per_cnt_r + 16'h0001;
         end
         else if (per_cnt_r != CCG_PERIOD_MAX)
         begin
            per_cnt_r <= per_cnt_r + 16'h0001;
         end
         if (ext_edge)
         begin
            if (trans_cnt_r >= factor - 5'h01)
            begin
               trans_cnt_r <= 5'h00;
               // Halfway steps avoid abrupt jumps in the output rate.
               target_r <= 16'((({1'b0, target_r} + {1'b0, period_r}) >> 1)); // R16
            end
            else
            begin
               trans_cnt_r <= trans_cnt_r + 5'h01;
            end
         end
      end
   end

   // Rate accumulator of the multiplied clock; toggles 2F times per target period.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         acc_r <= 17'h00000;
      end
      else if (acc_nxt >= {1'b0, target_r})
      begin
         // Clamping keeps the remainder below the target, so a saturated rate never wraps.
         acc_r <= (acc_sub >= {1'b0, target_r}) ? 17'h00000 : acc_sub; // R15
      end
      else
      begin
         acc_r <= acc_nxt;
      end
   end

   // CPU clock source selection. Multiplied rates are limited by the sampling clock.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpu_clock_r <= 1'b0;
      end
      else if (!cap_done_r)
      begin
         cpu_clock_r <= 1'b0;
      end
      else if (clock_fail_r)
      begin
         if (free_tick)
         begin
            cpu_clock_r <= ~cpu_clock_r; // R12 R13
         end
      end
      else if (mode_r == CCG_DIRECT)
      begin
         cpu_clock_r <= ext_s_r; // R06 R14
      end
      else if (mode_r == CCG_PRESCALE)
      begin
         if (ext_rise)
         begin
            cpu_clock_r <= ~cpu_clock_r; // R03 R04 R14
         end
      end
      else if (acc_nxt >= {1'b0, target_r})
      begin
         cpu_clock_r <= ~cpu_clock_r; // R02 R15
      end
   end

   property p_mode_hold;
      @(posedge clk) disable iff (!resetn) cap_done_r |=> $stable(mode_r) && cap_done_r;
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("Mode changed after capture."); // R17

   property p_fail_sticky;
      @(posedge clk) disable iff (!resetn) clock_fail_r |=> clock_fail_r [*8];
   endproperty
   a_fail_sticky: assert property (p_fail_sticky) else $error("Failure switch lost."); // R13

   property p_wdt_ovf;
      @(posedge clk) disable iff (!resetn)
         (wdt_active && !clock_fail_r && !ext_edge && free_tick && wdt_cnt_r == 5'h0F)
         |=> clock_fail_r && osc_wdt_irq_r;
   endproperty
   a_wdt_ovf: assert property (p_wdt_ovf) else $error("Overflow not flagged."); // R11

   property p_wdt_early;
      @(posedge clk) disable iff (!resetn)
         (!clock_fail_r && wdt_cnt_r < 5'h0F) |=> !clock_fail_r;
   endproperty
   a_wdt_early: assert property (p_wdt_early) else $error("Failure flagged too early."); // R11

   property p_wdt_clear;
      @(posedge clk) disable iff (!resetn) (wdt_active && ext_edge) |=> wdt_cnt_r == 5'h00;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("Counter not cleared."); // R10

   property p_wdt_idle;
      @(posedge clk) disable iff (!resetn) (cap_done_r && !non_pll) |=> wdt_cnt_r == 5'h00;
   endproperty
   a_wdt_idle: assert property (p_wdt_idle) else $error("Monitor counting in PLL mode."); // R09

   property p_irq_with_fail;
      @(posedge clk) disable iff (!resetn) $rose(clock_fail_r) |-> osc_wdt_irq_r;
   endproperty
   a_irq_with_fail: assert property (p_irq_with_fail) else $error("No request flag."); // R12

   property p_direct_follow;
      @(posedge clk) disable iff (!resetn)
         (cap_done_r && mode_r == CCG_DIRECT && !clock_fail_r)
         |=> clock_fail_r || cpu_clock_r == $past(ext_s_r);
   endproperty
   a_direct_follow: assert property (p_direct_follow) else $error("Direct clock wrong."); // R06

   property p_prescale;
      @(posedge clk) disable iff (!resetn)
         (cap_done_r && mode_r == CCG_PRESCALE && !clock_fail_r && ext_rise)
         |=> clock_fail_r || cpu_clock_r != $past(cpu_clock_r);
   endproperty
   a_prescale: assert property (p_prescale) else $error("Prescaler missed a toggle."); // R04

   property p_pll_power;
      @(posedge clk) disable iff (!resetn)
         cap_done_r |=> pll_on_r == ($past(!non_pll) || $past(!osc_watchdog_disable));
   endproperty
   a_pll_power: assert property (p_pll_power) else $error("PLL power wrong."); // R07

   c_fail: cover property (@(posedge clk) disable iff (!resetn) $rose(clock_fail_r));
   c_prescale: cover property (@(posedge clk) disable iff (!resetn)
      mode_r == CCG_PRESCALE && $rose(cpu_clock_r));
   c_pll: cover property (@(posedge clk) disable iff (!resetn)
      mode_r == CCG_MUL4 && cap_done_r && $rose(cpu_clock_r));
endmodule

// ---- verification/ccg_xtal_model.sv ----
// External crystal or clock source that drives the clock input pin.
`timescale 1ns/10ps
module ccg_xtal_model
(
   input wire logic run,
   input wire logic [15:0] half_ns,
   output logic pin
);
   // The odd start offset keeps pin edges away from both clock edges.
   // A stopped source holds its level, as a dead crystal would.
   initial
   begin
      pin = 1'b0;
      #7;
      forever
      begin
         #(half_ns);
         if (run)
         begin
            pin = ~pin;
         end
      end
   end
endmodule

// ---- verification/ccg_top_tb.sv ----
// Self-checking testbench for the CPU clock generator.
`timescale 1ns/10ps
module ccg_top_tb;
   import ccg_pkg::*;
   logic clk, resetn, dis, run, pin, cpu_clk, pll_on, bypass, fail, irq;
   logic [2:0] straps;
   ccg_mode_t mode;
   int n_fail, comparisons, cyc;
   ccg_xtal_model i_xtal (.run(run), .half_ns(16'h00AA), .pin(pin));
   ccg_top i_dut (.clk(clk), .resetn(resetn), .ext_clock_input_pin(pin),
      .clock_mode_straps(straps), .osc_watchdog_disable(dis), .cpu_clock_r(cpu_clk),
      .pll_on_r(pll_on), .osc_amp_bypass_r(bypass), .clock_fail_r(fail),
      .osc_wdt_irq_r(irq), .mode_r(mode));
   initial
   begin
      clk = 1'b0;
      forever
      begin
         #20 clk = ~clk;
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // The ceiling is several times the length of the whole sequence.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // Straps are turned round after capture, so a late capture shows up.
   task automatic do_reset(input logic [2:0] code, input logic d);
      @(negedge clk);
      resetn = 1'b0;
      straps = code;
      dis = d;
      run = 1'b1;
      repeat (8) @(negedge clk);
      check("mode_in_reset", mode, CCG_MODE_RESET);
      check("fail_in_reset", {cpu_clk, fail, irq}, 8'h00);
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      straps = ~code;
   endtask
   // Measures one high and the following low phase of the CPU clock in clk cycles.
   task automatic phases(input int lo, input int hi, input int slo, input int shi);
      int t, h, l;
      t = 0;
      h = 0;
      l = 0;
      while (cpu_clk !== 1'b0 && t < 200)
      begin
         @(negedge clk);
         t++;
      end
      while (cpu_clk !== 1'b1 && t < 200)
      begin
         @(negedge clk);
         t++;
      end
      while (cpu_clk === 1'b1 && h < 200)
      begin
         @(negedge clk);
         h++;
      end
      while (cpu_clk === 1'b0 && l < 200)
      begin
         @(negedge clk);
         l++;
      end
      check("high_phase", h >= lo && h <= hi, 1'b1);
      check("low_phase", l >= lo && l <= hi, 1'b1);
      check("phase_sum", h + l >= slo && h + l <= shi, 1'b1);
   endtask
   // Every code once; the multiplied clock must clearly outrun the input.
   task automatic t_modes();
      ccg_mode_t m;
      int ct, pt;
      logic pc, pp;
      m = m.first();
      do
      begin
         do_reset(m, 1'b0);
         check("mode", mode, m);
         check("bypass", bypass, m == CCG_DIRECT);
         check("pll_on", pll_on, 1'b1);
         if (m != CCG_DIRECT && m != CCG_PRESCALE)
         begin
            repeat (400) @(negedge clk);
            ct = 0;
            pt = 0;
            pc = cpu_clk;
            pp = pin;
            repeat (200)
            begin
               @(negedge clk);
               ct += (cpu_clk !== pc);
               pt += (pin !== pp);
               pc = cpu_clk;
               pp = pin;
            end
            check("pll_rate", ct >= 2 * pt, 1'b1);
            // Only the factor of three stays clear of the sampling limit, so it is held to ratio.
            if (m == CCG_MUL3)
            begin
               check("pll_rate_x3", 10 * ct >= 28 * pt && 10 * ct <= 34 * pt, 1'b1);
            end
         end
         m = m.next();
      end
      while (m != m.first());
   endtask
   task automatic t_fail();
      int n;
      do_reset(CCG_DIRECT, 1'b0);
      phases(4, 5, 8, 9);
      run = 1'b0;
      repeat (20) @(negedge clk);
      run = 1'b1;
      repeat (20) @(negedge clk);
      check("short_gap", fail, 1'b0);
      run = 1'b0;
      n = 0;
      while (fail !== 1'b1 && n < 80)
      begin
         @(negedge clk);
         n++;
      end
      check("fail_time", n >= 26 && n <= 40, 1'b1);
      check("irq", irq, 1'b1);
      run = 1'b1;
      repeat (50) @(negedge clk);
      check("fail_sticky", {fail, irq}, 8'h03);
      phases(2, 2, 4, 4);
   endtask
   task automatic t_quiet();
      do_reset(CCG_PRESCALE, 1'b0);
      phases(8, 9, 16, 18);
      do_reset(CCG_PRESCALE, 1'b1);
      check("pll_off", pll_on, 1'b0);
      run = 1'b0;
      repeat (100) @(negedge clk);
      check("off_no_fail", {fail, irq}, 8'h00);
      do_reset(CCG_MUL4, 1'b0);
      run = 1'b0;
      repeat (100) @(negedge clk);
      check("pll_no_fail", {fail, irq}, 8'h00);
   endtask
   initial
   begin
      n_fail = 0;
      comparisons = 0;
      cyc = 0;
      resetn = 1'b0;
      straps = 3'h7;
      dis = 1'b0;
      run = 1'b1;
      t_modes();
      t_fail();
      t_quiet();
      wrap_up();
   end
endmodule
